// [eci_ext_ctrl.sv]
// Overview of operation
// [R1] Init load copies the receive ring length code into bits 11-8.
// [R2] Ring length reads only under stop or suspend; writes ignored. Code also shows it in SUSP_DRAIN, before the suspend bit reads one.
// [R3] Bits 7-0 of the ring length word read zero always.
// [R4] Interrupt flags clear by writing one; read value written back clears.
// [R5] Quick suspend finishes started DMA and frames, then starts nothing.
// [R6] Flushing suspend drains all buffered frames before suspending.
// [R7] Suspend request write picks quick or flushing mode at that moment.
// [R8] Quick suspend enable always R/W; cleared by resets or stop.
// [R9] Frame tag enable inserts tags when selected; hard reset clears only.
// [R10] Receive demand fetches descriptors at once; inert with receiver off.
// [R11] Demand set by writing one, cleared on fetch or hard reset.
// [R12] Autopoll disable stops timed polling; software must use demand.
// [R13] Autopoll disable cleared only by hard reset.
// [R14] Timer zero sets its flag, reloads six-bit value, keeps counting.
// [R15] Timer flag clears by writing one; hard reset only.
// [R16] Timer enable lets flag raise summary interrupt; hard reset clears.
// [R17] The PHY drives management data low during read turnaround.
// [R18] Data not low in turnaround sets the management read error flag.
// [R19] Read error flag clears by writing one; hard reset only.
// [R20] Read error enable lets flag raise summary; hard reset clears.
// [R21] Software polls suspend bit until one before assuming suspended.
// [R22] Summary interrupt is OR of flags ANDed with enables.
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "eci_params.svh"
module eci_ext_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Register bus
  input wire eci_pkg::eci_axil_req_s axi_req,
  output eci_pkg::eci_axil_rsp_s axi_rsp,
  // Soft reset and initialization
  input wire logic soft_reset,
  input wire logic init_load,
  input wire logic [3:0] init_rx_ring_len,
  // Receive descriptor polling and tagging
  input wire logic receiver_on,
  input wire logic poll_tick,
  input wire logic rx_desc_fetched,
  output logic rx_desc_fetch_req,
  output logic rx_tag_insert,
  // Datapath activity for suspend
  input wire logic dma_busy,
  input wire logic tx_frame_busy,
  input wire logic rx_frame_busy,
  input wire logic tx_buffered,
  input wire logic rx_buffered,
  output logic halt_intake,
  output logic halt_all,
  output logic suspended,
  // Management read turnaround check
  input wire logic mgmt_turnaround_strobe,
  input wire logic mgmt_data_in,
  // Interrupt
  output logic summary_interrupt
);
  import eci_pkg::*;
  logic wr_en, wr_ok, rd_ok, tmr_expire;
  logic [`ECI_AW-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [3:0] wr_strb;
  logic [3:0] rx_ring_len_code;
  logic quick_suspend_enable, rx_frame_tag_enable, rx_poll_demand;
  logic rx_autopoll_disable, sw_timer_irq_flag, sw_timer_irq_enable;
  logic mgmt_read_error_flag, mgmt_read_error_enable;
  logic stop_reg, fast_reg, poll_pend_reg, ext_addr_detect_select;
  logic [`ECI_TMR_MSB:0] sw_timer_reload;
  eci_susp_e state_reg, state_next;
  logic [31:0] ring_rd, xctl_rd, ctrl_rd, tmr_rd, misc_rd;

  // Bus slave front end
  eci_axil_slave u_bus (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .req(axi_req),
    .rsp(axi_rsp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Software timer with reload
  eci_sw_timer u_tmr (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reload(sw_timer_reload),
    .expire(tmr_expire)
  );

  // Address decode and byte lane masking
  wire hit_ring = (wr_addr == `ECI_OFS_RING);
  wire hit_xctl = (wr_addr == `ECI_OFS_XCTL);
  wire hit_ctrl = (wr_addr == `ECI_OFS_CTRL);
  wire hit_tmr = (wr_addr == `ECI_OFS_TMR);
  wire hit_misc = (wr_addr == `ECI_OFS_MISC);
  assign wr_ok = hit_ring | hit_xctl | hit_ctrl | hit_tmr | hit_misc;
  wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire [15:0] wbits = wr_data[15:0] & wmask;
  wire wr_x = wr_en & hit_xctl;
  wire wr_c = wr_en & hit_ctrl;

  // Control strobes
  wire stop_set = wr_c & wbits[`ECI_B_STOP];
  wire susp_kill = soft_reset | stop_set;
  wire susp_wr = wr_c & wmask[`ECI_B_SUSP];
  wire susp_go = susp_wr & wr_data[`ECI_B_SUSP] & !stop_reg & !susp_kill;
  wire susp_leave = susp_wr & !wr_data[`ECI_B_SUSP];
  wire mgmt_err_evt = mgmt_turnaround_strobe & mgmt_data_in; // [R18]

  // Ring length copy, kept across every reset
  always_ff @(posedge sys_clk)
  begin
    if (init_load)
      rx_ring_len_code <= init_rx_ring_len; // [R1]
  end

  // Bits cleared by hard reset, soft reset or stop
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      quick_suspend_enable <= 1'b0;
    else if (susp_kill)
      quick_suspend_enable <= 1'b0; // [R8]
    else if (wr_x & wmask[`ECI_B_QSE])
      quick_suspend_enable <= wr_data[`ECI_B_QSE]; // [R8]
  end

  // Bits cleared by hard reset only
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_frame_tag_enable <= 1'b0;
      rx_autopoll_disable <= 1'b0;
      sw_timer_irq_enable <= 1'b0;
      mgmt_read_error_enable <= 1'b0;
    end
    else if (wr_x)
    begin
      if (wmask[`ECI_B_TAG])
        rx_frame_tag_enable <= wr_data[`ECI_B_TAG]; // [R9]
      if (wmask[`ECI_B_APD])
        rx_autopoll_disable <= wr_data[`ECI_B_APD]; // [R13]
      if (wmask[`ECI_B_STE])
        sw_timer_irq_enable <= wr_data[`ECI_B_STE]; // [R16]
      if (wmask[`ECI_B_MRE])
        mgmt_read_error_enable <= wr_data[`ECI_B_MRE]; // [R20]
    end
  end

  // Sticky flags, a new event beats a same-cycle clear
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sw_timer_irq_flag <= 1'b0;
      mgmt_read_error_flag <= 1'b0;
    end
    else
    begin
      if (tmr_expire)
        sw_timer_irq_flag <= 1'b1; // [R14]
      else if (wr_x & wbits[`ECI_B_STF])
        sw_timer_irq_flag <= 1'b0; // [R4] [R15]
      if (mgmt_err_evt)
        mgmt_read_error_flag <= 1'b1; // [R18]
      else if (wr_x & wbits[`ECI_B_MRF])
        mgmt_read_error_flag <= 1'b0; // [R4] [R19]
    end
  end

  // Receive demand and timed poll request
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rx_poll_demand <= 1'b0;
      poll_pend_reg <= 1'b0;
    end
    else
    begin
      if (wr_x & wbits[`ECI_B_DMD])
        rx_poll_demand <= 1'b1; // [R11]
      else if (rx_desc_fetched)
        rx_poll_demand <= 1'b0; // [R11]
      if (poll_tick & !rx_autopoll_disable & receiver_on)
        poll_pend_reg <= 1'b1; // [R12]
      else if (rx_desc_fetched | rx_autopoll_disable)
        poll_pend_reg <= 1'b0; // [R12]
    end
  end

  // Descriptor fetch only with the receiver on
  assign rx_desc_fetch_req = receiver_on &
    (rx_poll_demand | poll_pend_reg); // [R10] [R12]
  assign rx_tag_insert = rx_frame_tag_enable &
    ext_addr_detect_select; // [R9]

  // Own control, reload and configuration registers
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      stop_reg <= `ECI_RST_STOP;
      sw_timer_reload <= `ECI_RST_RELOAD;
      ext_addr_detect_select <= 1'b0;
    end
    else
    begin
      if (wr_c & wmask[`ECI_B_STOP])
        stop_reg <= wr_data[`ECI_B_STOP];
      if (wr_en & hit_tmr & wr_strb[0])
        sw_timer_reload <= wr_data[`ECI_TMR_MSB:0];
      if (wr_en & hit_misc & wr_strb[0])
        ext_addr_detect_select <= wr_data[`ECI_B_EADS];
    end
  end

  // Suspend mode chosen at the request write
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      fast_reg <= 1'b0;
    else if (susp_go & (state_reg == SUSP_RUN))
      fast_reg <= quick_suspend_enable; // [R7]
  end

  // Conditions for completing the drain
  wire work_done = !dma_busy & !tx_frame_busy & !rx_frame_busy; // [R5]
  wire bufs_empty = !tx_buffered & !rx_buffered; // [R6]
  wire drain_done = work_done & (fast_reg | bufs_empty);

  // Suspend sequencer next state
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SUSP_RUN:
        if (susp_go)
          state_next = SUSP_DRAIN;
      SUSP_DRAIN:
        if (drain_done)
          state_next = SUSP_HALT; // [R5] [R6]
      SUSP_HALT:
        state_next = SUSP_HALT;
      default:
        state_next = SUSP_RUN;
    endcase
    if (susp_kill | susp_leave)
      state_next = SUSP_RUN;
  end

  // Suspend sequencer state
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      state_reg <= SUSP_RUN;
    else
      state_reg <= state_next;
  end

  // Datapath throttles
  assign halt_intake = (state_reg != SUSP_RUN); // [R6]
  assign halt_all = (state_reg == SUSP_HALT) |
    ((state_reg == SUSP_DRAIN) & fast_reg); // [R5]
  assign suspended = (state_reg == SUSP_HALT);

  // Summary interrupt
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
      summary_interrupt <= 1'b0;
    else
      summary_interrupt <= (sw_timer_irq_flag & sw_timer_irq_enable) |
        (mgmt_read_error_flag & mgmt_read_error_enable); // [R16] [R20] [R22]
  end

  // Read words
  wire ring_vis = stop_reg | (state_reg != SUSP_RUN); // [R2]
  always_comb
  begin
    ring_rd = '0; // [R3]
    if (ring_vis)
      ring_rd[`ECI_RX_RING_LEN_CODE_MSB:`ECI_RX_RING_LEN_CODE_LSB] = rx_ring_len_code; // [R2]
    xctl_rd = '0;
    xctl_rd[`ECI_B_QSE] = quick_suspend_enable;
    xctl_rd[`ECI_B_TAG] = rx_frame_tag_enable;
    xctl_rd[`ECI_B_DMD] = rx_poll_demand;
    xctl_rd[`ECI_B_APD] = rx_autopoll_disable;
    xctl_rd[`ECI_B_STF] = sw_timer_irq_flag;
    xctl_rd[`ECI_B_STE] = sw_timer_irq_enable;
    xctl_rd[`ECI_B_MRF] = mgmt_read_error_flag;
    xctl_rd[`ECI_B_MRE] = mgmt_read_error_enable;
    ctrl_rd = '0;
    ctrl_rd[`ECI_B_SUSP] = suspended; // [R21]
    ctrl_rd[`ECI_B_STOP] = stop_reg;
    tmr_rd = '0;
    tmr_rd[`ECI_TMR_MSB:0] = sw_timer_reload;
    misc_rd = '0;
    misc_rd[`ECI_B_EADS] = ext_addr_detect_select;
  end

  // Read selection
  wire rd_ring = (rd_addr == `ECI_OFS_RING);
  wire rd_xctl = (rd_addr == `ECI_OFS_XCTL);
  wire rd_ctrl = (rd_addr == `ECI_OFS_CTRL);
  wire rd_tmr = (rd_addr == `ECI_OFS_TMR);
  wire rd_misc = (rd_addr == `ECI_OFS_MISC);
  assign rd_ok = rd_ring | rd_xctl | rd_ctrl | rd_tmr | rd_misc;
  assign rd_data = rd_ring ? ring_rd :
    rd_xctl ? xctl_rd :
    rd_ctrl ? ctrl_rd :
    rd_tmr ? tmr_rd :
    rd_misc ? misc_rd : '0;

  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  property p_ring_hidden;
    !ring_vis |-> ring_rd == '0;
  endproperty
  a_ring_hidden: assert property (p_ring_hidden) // [R2]
    else $error("ring length visible while running");

  property p_low_zero;
    ring_rd[7:0] == 8'h00;
  endproperty
  a_low_zero: assert property (p_low_zero) // [R3]
    else $error("ring length low byte not zero");

  property p_tmr_flag;
    tmr_expire |=> sw_timer_irq_flag ##1
      (sw_timer_irq_flag || $past(wr_x && wbits[`ECI_B_STF]));
  endproperty
  a_tmr_flag: assert property (p_tmr_flag) // [R14]
    else $error("timer expiry lost");

  property p_w1c;
    wr_x & wbits[`ECI_B_STF] & !tmr_expire |=> !sw_timer_irq_flag;
  endproperty
  a_w1c: assert property (p_w1c) // [R15]
    else $error("timer flag not cleared by write one");

  property p_mre_set;
    mgmt_err_evt |=> mgmt_read_error_flag;
  endproperty
  a_mre_set: assert property (p_mre_set) // [R18]
    else $error("read error not flagged");

  property p_no_poll_off;
    !receiver_on |-> !rx_desc_fetch_req;
  endproperty
  a_no_poll_off: assert property (p_no_poll_off) // [R10]
    else $error("descriptor fetch with receiver off");

  property p_demand_clr;
    rx_desc_fetched & !wr_x |=> !rx_poll_demand;
  endproperty
  a_demand_clr: assert property (p_demand_clr) // [R11]
    else $error("demand not cleared on fetch");

  property p_fast_done;
    state_reg == SUSP_DRAIN && fast_reg && work_done && !susp_kill
      && !susp_leave |=> suspended;
  endproperty
  a_fast_done: assert property (p_fast_done) // [R5]
    else $error("quick suspend not entered");

  property p_flush_wait;
    state_reg == SUSP_DRAIN && !fast_reg && tx_buffered |=> !suspended;
  endproperty
  a_flush_wait: assert property (p_flush_wait) // [R6]
    else $error("suspended with transmit data buffered");

  property p_qse_stop;
    stop_set |=> !quick_suspend_enable;
  endproperty
  a_qse_stop: assert property (p_qse_stop) // [R8]
    else $error("quick suspend enable survived stop");

  property p_summary;
    sw_timer_irq_flag & sw_timer_irq_enable & !wr_x |=> summary_interrupt;
  endproperty
  a_summary: assert property (p_summary) // [R22]
    else $error("summary interrupt missing");

  c_suspend_fast: cover property (state_reg == SUSP_DRAIN && fast_reg
    ##[1:20] suspended);
  c_suspend_flush: cover property (state_reg == SUSP_DRAIN && !fast_reg
    ##[1:20] suspended);
  c_timer_irq: cover property (tmr_expire ##2 summary_interrupt);
  c_demand_fetch: cover property (rx_poll_demand && rx_desc_fetched);
endmodule // eci_ext_ctrl

// [eci_params.svh]
`ifndef ECI_PARAMS_SVH
`define ECI_PARAMS_SVH
// Register byte offsets
`define ECI_OFS_RING 8'h00
`define ECI_OFS_XCTL 8'h04
`define ECI_OFS_CTRL 8'h08
`define ECI_OFS_TMR 8'h0c
`define ECI_OFS_MISC 8'h10
// Ring length field
`define ECI_RX_RING_LEN_CODE_MSB 11
`define ECI_RX_RING_LEN_CODE_LSB 8
// Extended control bit positions
`define ECI_B_QSE 15
`define ECI_B_TAG 14
`define ECI_B_DMD 13
`define ECI_B_APD 12
`define ECI_B_STF 11
`define ECI_B_STE 10
`define ECI_B_MRF 9
`define ECI_B_MRE 8
// Control and misc bit positions
`define ECI_B_SUSP 0
`define ECI_B_STOP 2
`define ECI_B_EADS 3
`define ECI_TMR_MSB 5
// Reset values
`define ECI_RST_STOP 1'b1
`define ECI_RST_RELOAD 6'h3f
`define ECI_RST_COUNT 6'h3f
// Timer tick timing
`define ECI_CLK_NS 20
`define ECI_TICK_NS 10240
`define ECI_TICK_CYC (`ECI_TICK_NS / `ECI_CLK_NS)
// Bus responses and widths
`define ECI_RESP_OK 2'b00
`define ECI_RESP_ERR 2'b10
`define ECI_AW 8
`endif

// [eci_pkg.sv]
`include "eci_params.svh"
package eci_pkg;
  // AXI4-Lite master to slave signals
  typedef struct packed {
    logic awvalid;
    logic [`ECI_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`ECI_AW-1:0] araddr;
    logic rready;
  } eci_axil_req_s;
  // AXI4-Lite slave to master signals
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } eci_axil_rsp_s;
  // Suspend sequencer states
  typedef enum logic [1:0] {
    SUSP_RUN = 2'b00,
    SUSP_DRAIN = 2'b01,
    SUSP_HALT = 2'b10
  } eci_susp_e;
endpackage

// [eci_sw_timer.sv]
`timescale 1ns/1ns
`include "eci_params.svh"
module eci_sw_timer (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Reload value and expiry pulse
  input wire logic [`ECI_TMR_MSB:0] reload,
  output logic expire
);
  logic [9:0] pre_reg;
  logic [`ECI_TMR_MSB:0] cnt_reg;
  logic tick;
  logic at_zero;
  // Prescaler tick and zero detect
  assign tick = (pre_reg == 10'(`ECI_TICK_CYC - 1));
  assign at_zero = (cnt_reg == '0);
  assign expire = tick & at_zero;
  // Down counter, reloads on the tick after it reaches zero
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pre_reg <= '0;
      cnt_reg <= `ECI_RST_COUNT;
    end
    else
    begin
      pre_reg <= tick ? '0 : pre_reg + 10'd1;
      if (tick)
        cnt_reg <= at_zero ? reload : cnt_reg - 6'd1;
    end
  end
endmodule // eci_sw_timer

// [eci_axil_slave.sv]
`timescale 1ns/1ns
`include "eci_params.svh"
module eci_axil_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus side
  input wire eci_pkg::eci_axil_req_s req,
  output eci_pkg::eci_axil_rsp_s rsp,
  // Register side write
  output logic wr_en,
  output logic [`ECI_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  // Register side read
  output logic [`ECI_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import eci_pkg::*;
  logic aw_reg, w_reg, bv_reg, rv_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;
  logic aw_rdy, w_rdy, ar_rdy, rd_en;
  // Ready terms and register strobes
  assign aw_rdy = !aw_reg & !bv_reg;
  assign w_rdy = !w_reg & !bv_reg;
  assign ar_rdy = !rv_reg;
  assign rd_en = req.arvalid & ar_rdy;
  assign rd_addr = req.araddr;
  assign wr_en = aw_reg & w_reg & !bv_reg;
  // Response bundle
  always_comb
  begin
    rsp = '0;
    rsp.awready = aw_rdy;
    rsp.wready = w_rdy;
    rsp.bvalid = bv_reg;
    rsp.bresp = bresp_reg;
    rsp.arready = ar_rdy;
    rsp.rvalid = rv_reg;
    rsp.rdata = rdata_reg;
    rsp.rresp = rresp_reg;
  end
  // Address and data capture in either order
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end
    else
    begin
      if (req.awvalid & aw_rdy)
      begin
        aw_reg <= 1'b1;
        wr_addr <= req.awaddr;
      end
      if (req.wvalid & w_rdy)
      begin
        w_reg <= 1'b1;
        wr_data <= req.wdata;
        wr_strb <= req.wstrb;
      end
      if (wr_en)
      begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
      end
    end
  end
  // Write and read responses
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bv_reg <= 1'b0;
      bresp_reg <= `ECI_RESP_OK;
      rv_reg <= 1'b0;
      rresp_reg <= `ECI_RESP_OK;
      rdata_reg <= '0;
    end
    else
    begin
      if (wr_en)
      begin
        bv_reg <= 1'b1;
        bresp_reg <= wr_ok ? `ECI_RESP_OK : `ECI_RESP_ERR;
      end
      else if (req.bready)
        bv_reg <= 1'b0;
      if (rd_en)
      begin
        rv_reg <= 1'b1;
        rdata_reg <= rd_ok ? rd_data : '0;
        rresp_reg <= rd_ok ? `ECI_RESP_OK : `ECI_RESP_ERR;
      end
      else if (req.rready)
        rv_reg <= 1'b0;
    end
  end
endmodule // eci_axil_slave

// [eci_ext_ctrl_tb.sv]
`timescale 1ns/1ns
`include "eci_params.svh"
module eci_ext_ctrl_tb;
  import eci_pkg::*;
  // Stimulus, responses and tallies
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_reset = 1'b0;
  logic init_load = 1'b0;
  logic [3:0] init_rx_ring_len = 4'h5;
  logic receiver_on = 1'b0;
  logic poll_tick = 1'b0;
  logic rx_desc_fetched = 1'b0;
  logic dma_busy = 1'b0;
  logic tx_frame_busy = 1'b0;
  logic rx_frame_busy = 1'b0;
  logic tx_buffered = 1'b0;
  logic rx_buffered = 1'b0;
  logic mgmt_turnaround_strobe = 1'b0;
  logic mgmt_data_in = 1'b0;
  logic rx_desc_fetch_req, rx_tag_insert, halt_intake, halt_all;
  logic suspended, summary_interrupt;
  eci_axil_req_s axi_req = '0;
  eci_axil_rsp_s axi_rsp;
  int num_errors = 0;
  int num_checks = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  time t0;

  // Block under test
  eci_ext_ctrl dut_u (
    .sys_clk, .sys_rst, .axi_req, .axi_rsp, .soft_reset, .init_load,
    .init_rx_ring_len, .receiver_on, .poll_tick, .rx_desc_fetched,
    .rx_desc_fetch_req, .rx_tag_insert, .dma_busy, .tx_frame_busy,
    .rx_frame_busy, .tx_buffered, .rx_buffered, .halt_intake, .halt_all,
    .suspended, .mgmt_turnaround_strobe, .mgmt_data_in, .summary_interrupt
  );

  // Clock generation
  initial
  begin
    forever #10 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Comparison of one value
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A wait that ran out of its bound
  task automatic hang(input string nm);
    num_errors++;
    $display("mismatch %s expected done seen timeout", nm);
    results();
  endtask

  // Idle clock cycles
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // Bus write; address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    axi_req.awvalid <= 1'b1;
    axi_req.awaddr <= a;
    axi_req.wvalid <= 1'b1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hf;
    axi_req.bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (axi_req.awvalid && axi_rsp.awready)
        axi_req.awvalid <= 1'b0;
      if (axi_req.wvalid && axi_rsp.wready)
        axi_req.wvalid <= 1'b0;
      if (axi_req.bready && axi_rsp.bvalid)
        break;
    end
    if (n == 50)
      hang("write");
    rsp = axi_rsp.bresp;
    axi_req.bready <= 1'b0;
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge sys_clk);
    axi_req.arvalid <= 1'b1;
    axi_req.araddr <= a;
    axi_req.rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge sys_clk);
      if (axi_req.arvalid && axi_rsp.arready)
        axi_req.arvalid <= 1'b0;
      if (axi_req.rready && axi_rsp.rvalid)
        break;
    end
    if (n == 50)
      hang("read");
    rd = axi_rsp.rdata;
    rsp = axi_rsp.rresp;
    axi_req.rready <= 1'b0;
  endtask

  // Read a register and compare
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk($sformatf("reg %h", a), rd, exp);
  endtask

  // Software polls the suspend bit until it reads one
  task automatic wait_susp();
    int n;
    for (n = 0; n < 20; n++)
    begin
      axi_rd(8'h08);
      if (rd[0] === 1'b1)
        break;
    end
    if (n == 20)
      hang("suspend");
    chk("suspended", suspended, 1'b1);
  endtask

  // Wait for the summary interrupt
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim; n++)
    begin
      @(posedge sys_clk);
      if (summary_interrupt === 1'b1)
        break;
    end
    if (n == lim)
      hang("interrupt");
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h4);
    rchk(8'h0c, 32'h3f);
    init_load <= 1'b1;
    cyc(1);
    init_load <= 1'b0;
    rchk(8'h00, 32'h500);
    axi_wr(8'h00, 32'hffff_ffff);
    rchk(8'h00, 32'h500);
    axi_wr(8'h08, 32'h0);
    rchk(8'h00, 32'h0);
    axi_wr(8'h14, 32'h1);
    chk("bresp", rsp, `ECI_RESP_ERR);
    rchk(8'h14, 32'h0);
    chk("rresp", rsp, `ECI_RESP_ERR);
    // Demand and timed polling
    axi_wr(8'h04, 32'hffff);
    rchk(8'h04, 32'hf500);
    chk("fetch off", rx_desc_fetch_req, 1'b0);
    receiver_on <= 1'b1;
    cyc(1);
    chk("fetch on", rx_desc_fetch_req, 1'b1);
    rx_desc_fetched <= 1'b1;
    cyc(1);
    rx_desc_fetched <= 1'b0;
    rchk(8'h04, 32'hd500);
    poll_tick <= 1'b1;
    cyc(1);
    poll_tick <= 1'b0;
    cyc(1);
    chk("no autopoll", rx_desc_fetch_req, 1'b0);
    // Quick suspend with data still buffered
    dma_busy <= 1'b1;
    rx_frame_busy <= 1'b1;
    tx_buffered <= 1'b1;
    axi_wr(8'h08, 32'h1);
    rchk(8'h08, 32'h0);
    chk("quick halt", halt_all, 1'b1);
    dma_busy <= 1'b0;
    rx_frame_busy <= 1'b0;
    wait_susp();
    rchk(8'h00, 32'h500);
    axi_wr(8'h08, 32'h0);
    // Management read turnaround
    mgmt_turnaround_strobe <= 1'b1;
    cyc(1);
    mgmt_data_in <= 1'b1;
    cyc(1);
    chk("no error", summary_interrupt, 1'b0);
    mgmt_turnaround_strobe <= 1'b0;
    mgmt_data_in <= 1'b0;
    cyc(2);
    chk("error irq", summary_interrupt, 1'b1);
    soft_reset <= 1'b1;
    cyc(1);
    soft_reset <= 1'b0;
    rchk(8'h04, 32'h5700);
    axi_wr(8'h04, 32'h5500);
    rchk(8'h04, 32'h5700);
    axi_wr(8'h04, 32'h4700);
    rchk(8'h04, 32'h4500);
    chk("sum clear", summary_interrupt, 1'b0);
    poll_tick <= 1'b1;
    cyc(1);
    poll_tick <= 1'b0;
    cyc(1);
    chk("autopoll", rx_desc_fetch_req, 1'b1);
    axi_wr(8'h10, 32'h8);
    chk("tag insert", rx_tag_insert, 1'b1);
    // Flushing suspend waits for buffered data
    axi_wr(8'h08, 32'h1);
    chk("flush", {halt_intake, halt_all, suspended}, 3'b100);
    tx_buffered <= 1'b0;
    wait_susp();
    axi_wr(8'h08, 32'h0);
    // Software timer expiry and reload
    axi_wr(8'h0c, 32'h2);
    wait_irq(40000);
    t0 = $time;
    rchk(8'h04, 32'h4d00);
    axi_wr(8'h04, 32'h4d00);
    cyc(2);
    wait_irq(3000);
    chk("reload gap", 32'(($time - t0) / 20), 3 * `ECI_TICK_CYC);
    // Stop and hard reset
    axi_wr(8'h04, 32'hc500);
    axi_wr(8'h08, 32'h4);
    rchk(8'h04, 32'h4d00);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    rchk(8'h04, 32'h0);
    rchk(8'h00, 32'h500);
    results();
  end
endmodule // eci_ext_ctrl_tb
